// [verilog/tlf_top.sv]
// temperature limits, under-temperature fault reaction and command link
`timescale 1ns/1ps
module tlf_top
   import tlf_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             lnk_clk,
   input  wire logic             lnk_req_valid,
   input  wire tlf_pkg::tlf_req_s lnk_req,
   output tlf_pkg::tlf_rsp_s     lnk_rsp,
   output logic                  lnk_rsp_valid,
   output logic                  lnk_busy,
   input  wire logic             run_pin,
   input  wire logic [15:0]      temp_meas,
   input  wire logic [15:0]      unit_len,
   input  wire logic             ext_shutdown,
   output logic                  out_en,
   output logic                  ot_warn,
   output logic                  ut_warn,
   output logic                  ut_fault,
   output logic                  fault_latched
);
   import tlf_pkg::*;

   // ------------------------------------------------------------
   // linear to fixed point
   // ------------------------------------------------------------
   function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
      logic signed [47:0] man;
      logic [5:0]         sh;
      man = 48'(signed'(v[MAN_HI:0]));
      sh  = 6'(signed'(v[EXP_HI:EXP_LO])) + FIX_BIAS;
      return man <<< sh;
   endfunction : lin_fix

   // ------------------------------------------------------------
   // link side: capture request, return answer
   // ------------------------------------------------------------
   logic     lrst;
   logic     ack_s;
   logic     ack_s_d;
   logic     req_tgl_q;
   logic     ack_tgl_q;
   tlf_req_s hold_q;
   tlf_rsp_s rsp_hold_q;
   wire      ack_edge = ack_s ^ ack_s_d;

   tlf_sync u_lrst (.clk(lnk_clk), .d(srst), .q(lrst));
   tlf_sync u_ack  (.clk(lnk_clk), .d(ack_tgl_q), .q(ack_s));

   // one request in flight; hold_q stays still until its answer returns
   always_ff @(posedge lnk_clk) begin
      if (lrst) begin
         req_tgl_q     <= 1'b0;
         lnk_busy      <= 1'b0;
         hold_q        <= '0;
         ack_s_d       <= 1'b0;
         lnk_rsp_valid <= 1'b0;
         lnk_rsp       <= '0;
      end else begin
         ack_s_d       <= ack_s;
         lnk_rsp_valid <= ack_edge;
         if (lnk_req_valid && !lnk_busy) begin
            hold_q    <= lnk_req;
            req_tgl_q <= ~req_tgl_q;
            lnk_busy  <= 1'b1;
         end else if (ack_edge) begin
            lnk_busy <= 1'b0;
         end
         if (ack_edge) begin
            lnk_rsp <= rsp_hold_q;
         end
      end
   end

   // ------------------------------------------------------------
   // core side: request arrival and decode
   // ------------------------------------------------------------
   logic       req_s;
   logic       req_s_d;
   logic       pin_s;
   logic [15:0] otw_q;
   logic [15:0] utw_q;
   logic [15:0] utf_q;
   logic [7:0]  utr_q;
   logic [7:0]  oper_q;
   logic [2:0]  stat_q;
   wire        go     = req_s ^ req_s_d;
   wire        wr     = go && hold_q.write;
   wire [7:0]  code   = hold_q.code;
   wire        wr_otw = wr && (code == CMD_OTW);
   wire        wr_utw = wr && (code == CMD_UTW);
   wire        wr_utf = wr && (code == CMD_UTF);
   wire        wr_utr = wr && (code == CMD_UTR);
   wire        wr_opr = wr && (code == CMD_OPER);
   wire        wr_clr = wr && (code == CMD_CLR);
   wire        wr_st  = wr && (code == CMD_STAT);
   wire [7:0]  stat_byte = {1'b0, stat_q, 4'h0};
   wire        known = (code == CMD_OTW) || (code == CMD_UTW) || (code == CMD_UTF)
                    || (code == CMD_UTR) || (code == CMD_OPER) || (code == CMD_CLR)
                    || (code == CMD_STAT);
   wire [15:0] rd_data = (code == CMD_OTW)  ? otw_q :
                         (code == CMD_UTW)  ? utw_q :
                         (code == CMD_UTF)  ? utf_q :
                         (code == CMD_UTR)  ? {8'h00, utr_q} :
                         (code == CMD_OPER) ? {8'h00, oper_q} :
                         (code == CMD_STAT) ? {8'h00, stat_byte} : 16'h0000;

   tlf_sync u_req (.clk(ref_clk), .d(req_tgl_q), .q(req_s));
   tlf_sync u_pin (.clk(ref_clk), .d(run_pin), .q(pin_s));

   // answer is parked on the same edge the toggle flips; the two sync flops let the link see it settled
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         req_s_d    <= 1'b0;
         ack_tgl_q  <= 1'b0;
         rsp_hold_q <= '0;
      end else begin
         req_s_d <= req_s;
         if (go) begin
            rsp_hold_q <= '{nack: !known, data: hold_q.write ? 16'h0000 : rd_data};
            ack_tgl_q  <= ~ack_tgl_q;
         end
      end
   end

   // ------------------------------------------------------------
   // settings; a byte command takes only the low byte
   // ------------------------------------------------------------
   // threshold and reaction storage
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         otw_q  <= RST_OTW;
         utw_q  <= RST_UTW;
         utf_q  <= RST_UTF;
         utr_q  <= RST_UTR;
         oper_q <= RST_OPER;
      end else begin
         if (wr_otw) otw_q <= hold_q.data;
         if (wr_utw) utw_q <= hold_q.data;
         if (wr_utf) utf_q <= hold_q.data;
         if (wr_utr) utr_q <= hold_q.data[7:0];
         if (wr_opr) oper_q <= hold_q.data[7:0];
      end
   end

   // ------------------------------------------------------------
   // limit comparison
   // ------------------------------------------------------------
   wire signed [47:0] meas_fix = lin_fix(temp_meas);
   wire ot_now  = meas_fix > lin_fix(otw_q);
   wire utw_now = meas_fix < lin_fix(utw_q);
   wire utf_now = meas_fix < lin_fix(utf_q);
   wire [2:0] flag_now = {ot_now, utw_now, utf_now};

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ot_warn  <= 1'b0;
         ut_warn  <= 1'b0;
         ut_fault <= 1'b0;
      end else begin
         ot_warn  <= ot_now;
         ut_warn  <= utw_now;
         ut_fault <= utf_now;
      end
   end

   // sticky status, write one to clear; a new event beats the clear
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_stat
         wire clr_bit = wr_clr || (wr_st && hold_q.data[ST_LO + gi]);
         always_ff @(posedge ref_clk) begin
            if (srst) stat_q[gi] <= 1'b0;
            else      stat_q[gi] <= flag_now[gi] || (stat_q[gi] && !clr_bit);
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // delay timer: 2^n units of unit_len cycles each
   // ------------------------------------------------------------
   logic [15:0] pre_q;
   logic [8:0]  units_q;
   logic        tmr_on_q;
   logic        tmr_load;
   // unit length from the delay unit setting; zero acts as one
   wire [15:0] unit_m1 = (unit_len == 16'h0000) ? 16'h0000 : unit_len - 16'h0001;
   wire [8:0]  dly_units = 9'(9'h001 << utr_q[DLY_HI:DLY_LO]);
   wire        tmr_done  = tmr_on_q && (pre_q == 16'h0000) && (units_q == 9'h001);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tmr_on_q <= 1'b0;
         pre_q    <= 16'h0000;
         units_q  <= 9'h000;
      end else if (tmr_load) begin
         tmr_on_q <= 1'b1;
         pre_q    <= unit_m1;
         units_q  <= dly_units;
      end else if (tmr_done) begin
         tmr_on_q <= 1'b0;
      end else if (tmr_on_q && pre_q == 16'h0000) begin
         pre_q   <= unit_m1;
         units_q <= units_q - 9'h001;
      end else if (tmr_on_q) begin
         pre_q <= pre_q - 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // fault reaction state machine
   // ------------------------------------------------------------
   tlf_state_e state_q;
   tlf_state_e state_d;
   logic [2:0] try_q;
   logic       try_inc;
   logic       try_clr;
   wire [1:0]  rsp = utr_q[RSP_HI:RSP_LO];
   wire [2:0]  rty = utr_q[RTY_HI:RTY_LO];
   wire        run_ok  = pin_s && oper_q[OPER_ON];
   wire        clr_evt = wr_clr || (wr_st && hold_q.data[ST_LO]);
   wire        fault_q = ut_fault;
   // no retries means straight to the latched state
   wire tlf_state_e retry_tgt = (rty == RTY_NONE) ? ST_LATCH : ST_WAIT;
   wire        try_last = (rty != RTY_FOREVER) && (3'(try_q + 3'h1) >= rty);

   always_comb begin
      state_d  = state_q;
      tmr_load = 1'b0;
      try_inc  = 1'b0;
      try_clr  = 1'b0;
      if (!run_ok) begin
         // commanded off ends any retry or latch
         state_d = ST_OFF;
      end else if (ext_shutdown) begin
         state_d = ST_LATCH;
      end else begin
         case (state_q)
            ST_OFF: begin
               state_d = ST_RUN;
               try_clr = 1'b1;
            end
            ST_RUN: begin
               if (fault_q) begin
                  case (rsp)
                     RSP_IGNORE: state_d = ST_RUN;
                     RSP_DELAY: begin
                        state_d  = ST_HOLD;
                        tmr_load = 1'b1;
                     end
                     RSP_DISRTY: begin
                        state_d  = retry_tgt;
                        tmr_load = 1'b1;
                        try_clr  = 1'b1;
                     end
                     default: state_d = ST_LATCH;
                  endcase
               end
            end
            ST_HOLD: begin
               if (tmr_done) begin
                  state_d  = fault_q ? retry_tgt : ST_RUN;
                  tmr_load = fault_q;
                  try_clr  = 1'b1;
               end
            end
            ST_WAIT: begin
               if (tmr_done) begin
                  state_d  = ST_TRY;
                  tmr_load = 1'b1;
               end
            end
            ST_TRY: begin
               if (fault_q) begin
                  try_inc  = 1'b1;
                  state_d  = try_last ? ST_LATCH : ST_WAIT;
                  tmr_load = tmr_done;
               end else if (tmr_done) begin
                  state_d = ST_RUN;
               end
            end
            ST_LATCH: begin
               // clear-faults or status clear releases the latch
               if (clr_evt) state_d = ST_RUN;
            end
            default: state_d = ST_OFF;
         endcase
      end
   end

   // output follows next state so it lines up with state_q
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q       <= ST_OFF;
         try_q         <= 3'h0;
         out_en        <= 1'b0;
         fault_latched <= 1'b0;
      end else begin
         state_q       <= state_d;
         try_q         <= try_clr ? 3'h0 : (try_inc ? 3'(try_q + 3'h1) : try_q);
         out_en        <= (state_d == ST_RUN) || (state_d == ST_HOLD) || (state_d == ST_TRY);
         fault_latched <= (state_d == ST_LATCH);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   wire live = run_ok && !ext_shutdown;

   sequence s_run_fault(logic [1:0] r);
      state_q == ST_RUN && fault_q && rsp == r && live;
   endsequence
   sequence s_try_fail;
      state_q == ST_TRY && fault_q && try_last && live;
   endsequence

   a_otw_write: assert property (wr_otw |=> otw_q == $past(hold_q.data))
      else $error("over-temp warning threshold not stored");
   a_utw_write: assert property (wr_utw |=> utw_q == $past(hold_q.data))
      else $error("under-temp warning threshold not stored");
   a_utf_write: assert property (wr_utf |=> utf_q == $past(hold_q.data))
      else $error("under-temp fault threshold not stored");
   a_react_write: assert property (wr_utr |=> utr_q == $past(hold_q.data[7:0]))
      else $error("reaction byte not stored");
   a_ignore_run: assert property (s_run_fault(RSP_IGNORE) |=> out_en ##1 out_en)
      else $error("ignored fault interrupted output");
   a_hold_delay: assert property (s_run_fault(RSP_DELAY) |=> state_q == ST_HOLD && out_en)
      else $error("delayed reaction did not keep running");
   a_disable_now: assert property (s_run_fault(RSP_DISRTY) |=> !out_en)
      else $error("disable and retry left output on");
   a_latch_stay: assert property (state_q == ST_LATCH && !clr_evt && run_ok |=> !out_en)
      else $error("latched fault restarted");
   a_clear_latch: assert property (state_q == ST_LATCH && clr_evt && live |=> out_en)
      else $error("clear did not release latch");
   a_no_retry: assert property (s_run_fault(RSP_DISRTY) && rty == RTY_NONE
                                |=> state_q == ST_LATCH)
      else $error("zero retries attempted restart");
   a_retry_limit: assert property (s_try_fail |=> state_q == ST_LATCH)
      else $error("retry budget not enforced");
   a_unit_count: assert property (tmr_load |=> units_q == $past(dly_units)
                                  && pre_q == $past(unit_m1))
      else $error("delay count not two to the n units");
   a_ot_flag: assert property (ot_now |=> ot_warn ##0 stat_q[2])
      else $error("over-temp warning not raised");

endmodule : tlf_top

// [verilog/tlf_pkg.sv]
// constants, types and command map of the temperature limit and fault reaction block
package tlf_pkg;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_OPER = 8'h01;
   localparam logic [7:0] CMD_CLR  = 8'h03;
   localparam logic [7:0] CMD_OTW  = 8'h51;
   localparam logic [7:0] CMD_UTW  = 8'h52;
   localparam logic [7:0] CMD_UTF  = 8'h53;
   localparam logic [7:0] CMD_UTR  = 8'h54;
   localparam logic [7:0] CMD_STAT = 8'h7D;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [15:0] RST_OTW  = 16'h007D;
   localparam logic [15:0] RST_UTW  = 16'h07D8;
   localparam logic [15:0] RST_UTF  = 16'h07D3;
   localparam logic [7:0]  RST_UTR  = 8'hC0;
   localparam logic [7:0]  RST_OPER = 8'h80;

   // ------------------------------------------------------------
   // field positions and encodings
   // ------------------------------------------------------------
   localparam int RSP_HI  = 7;
   localparam int RSP_LO  = 6;
   localparam int RTY_HI  = 5;
   localparam int RTY_LO  = 3;
   localparam int DLY_HI  = 2;
   localparam int DLY_LO  = 0;
   localparam int OPER_ON = 7;
   localparam int ST_LO   = 4;
   localparam int EXP_HI  = 15;
   localparam int EXP_LO  = 11;
   localparam int MAN_HI  = 10;
   localparam logic [5:0] FIX_BIAS = 6'h10;
   localparam logic [1:0] RSP_IGNORE = 2'b00;
   localparam logic [1:0] RSP_DELAY  = 2'b01;
   localparam logic [1:0] RSP_DISRTY = 2'b10;
   localparam logic [1:0] RSP_LATCH  = 2'b11;
   localparam logic [2:0] RTY_NONE    = 3'b000;
   localparam logic [2:0] RTY_FOREVER = 3'b111;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_RUN   = 3'b001,
      ST_HOLD  = 3'b010,
      ST_WAIT  = 3'b011,
      ST_TRY   = 3'b100,
      ST_LATCH = 3'b101
   } tlf_state_e;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } tlf_req_s;

   typedef struct packed {
      logic        nack;
      logic [15:0] data;
   } tlf_rsp_s;

endpackage : tlf_pkg

// [verilog/tlf_sync.sv]
// two-flop synchroniser for one level or toggle
`timescale 1ns/1ps
module tlf_sync (
   input  wire logic clk,
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   // first flop feeds only the second
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule : tlf_sync

// [verif/tlf_host_model.sv]
// behavioural host that issues one command at a time on the link
`timescale 1ns/1ps
module tlf_host_model
   import tlf_pkg::*;
(
   input  wire logic              lnk_clk,
   output logic                   lnk_req_valid,
   output tlf_pkg::tlf_req_s      lnk_req,
   input  wire tlf_pkg::tlf_rsp_s lnk_rsp,
   input  wire logic              lnk_rsp_valid,
   input  wire logic              lnk_busy
);
   // idle link after time zero
   initial begin
      lnk_req_valid = 1'b0;
      lnk_req       = '0;
   end

   // ------------------------------------------------------------
   // one transfer
   // ------------------------------------------------------------
   // payload is inverted once released so a stale word never looks valid
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       output tlf_rsp_s rsp, output logic ok);
      int   n;
      logic took;
      n   = 0;
      ok  = 1'b0;
      rsp = '0;
      @(negedge lnk_clk);
      while (lnk_busy !== 1'b0 && n < 50) begin
         @(negedge lnk_clk);
         n++;
      end
      lnk_req       = {wr, code, data};
      lnk_req_valid = 1'b1;
      @(negedge lnk_clk);
      lnk_req_valid = 1'b0;
      lnk_req       = ~lnk_req;
      // busy one cycle after the strobe shows the request was taken
      took          = lnk_busy;
      n             = 0;
      // answer pulse stands one cycle, still high at the following fall
      while (lnk_rsp_valid !== 1'b1 && n < 40) begin
         @(negedge lnk_clk);
         n++;
      end
      ok  = lnk_rsp_valid && took;
      rsp = lnk_rsp;
   endtask : xfer
endmodule : tlf_host_model

// [verif/tlf_top_tb.sv]
// self-checking bench for the temperature limits and fault reaction block
`timescale 1ns/1ps
module tlf_top_tb;
   import tlf_pkg::*;

   localparam logic [15:0] T_OK   = 16'h0014;
   localparam logic [15:0] T_COLD = 16'h0005;
   localparam logic [15:0] OT_T [6] = '{16'h0032, 16'h0032, 16'h0832, 16'h0832,
                                        16'h0032, 16'h0032};
   localparam logic [15:0] TM_T [6] = '{16'h0014, 16'h003C, 16'hF8B4, 16'hF8F0,
                                        16'h000C, 16'h0005};
   localparam logic [2:0]  FL_T [6] = '{3'b000, 3'b100, 3'b000, 3'b100, 3'b010, 3'b011};

   logic        ref_clk       = 1'b0;
   logic        lnk_clk       = 1'b0;
   logic        srst          = 1'b1;
   logic        run_pin       = 1'b1;
   logic        ext_shutdown  = 1'b0;
   logic [15:0] temp_meas     = T_OK;
   logic [15:0] unit_len      = 16'h0002;
   logic        lnk_req_valid;
   tlf_req_s    lnk_req;
   tlf_rsp_s    lnk_rsp;
   logic        lnk_rsp_valid;
   logic        lnk_busy;
   logic        out_en;
   logic        ot_warn;
   logic        ut_warn;
   logic        ut_fault;
   logic        fault_latched;
   int          n_mismatch    = 0;
   int          checks_done   = 0;

   // unrelated clocks: 5 ns core, 6 ns link
   always #2.5 ref_clk = ~ref_clk;
   always #3 lnk_clk = ~lnk_clk;

   tlf_top dut (.ref_clk(ref_clk), .srst(srst), .lnk_clk(lnk_clk),
      .lnk_req_valid(lnk_req_valid), .lnk_req(lnk_req), .lnk_rsp(lnk_rsp),
      .lnk_rsp_valid(lnk_rsp_valid), .lnk_busy(lnk_busy), .run_pin(run_pin),
      .temp_meas(temp_meas), .unit_len(unit_len), .ext_shutdown(ext_shutdown),
      .out_en(out_en), .ot_warn(ot_warn), .ut_warn(ut_warn), .ut_fault(ut_fault),
      .fault_latched(fault_latched));

   tlf_host_model host (.lnk_clk(lnk_clk), .lnk_req_valid(lnk_req_valid),
      .lnk_req(lnk_req), .lnk_rsp(lnk_rsp), .lnk_rsp_valid(lnk_rsp_valid),
      .lnk_busy(lnk_busy));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cycles

   task automatic set_temp(input logic [15:0] t);
      @(negedge ref_clk);
      temp_meas = t;
   endtask : set_temp

   // answer is compared whole: nack bit over the data word
   task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
                         input logic [16:0] exp);
      tlf_rsp_s rsp;
      logic     ok;
      host.xfer(wr, code, data, rsp, ok);
      check("answer arrived", 17'h1, {16'h0, ok});
      if (ok !== 1'b1) finish_test();
      check($sformatf("answer to code %h", code), exp, rsp);
      check("busy at answer", 17'h0, {16'h0, lnk_busy});
   endtask : access

   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      access(1'b1, code, data, 17'h0);
   endtask : wr

   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      access(1'b0, code, 16'h0, {1'b0, exp});
   endtask : rd

   // bounded wait on a level; running out ends the run
   task automatic wait_lvl(ref logic sig, input logic v, input int bound, input string what);
      int n;
      n = 0;
      while (sig !== v && n < bound) begin
         @(negedge ref_clk);
         n++;
      end
      check(what, {16'h0, v}, {16'h0, sig});
      if (sig !== v) finish_test();
   endtask : wait_lvl

   task automatic count_rises(input int window, output int rises, output int gap);
      int   t1;
      logic prev;
      rises = 0;
      gap   = 0;
      t1    = 0;
      prev  = out_en;
      for (int i = 0; i < window; i++) begin
         @(negedge ref_clk);
         if (out_en === 1'b1 && prev !== 1'b1) begin
            rises++;
            if (rises == 2) gap = i - t1;
            t1 = i;
         end
         prev = out_en;
      end
   endtask : count_rises

   task automatic recover;
      set_temp(T_OK);
      wr(CMD_CLR, 16'h0000);
      wait_lvl(out_en, 1'b1, 40, "output back on");
   endtask : recover

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   // reset spans enough edges of both clocks for the link side to see it
   initial begin
      int          rises;
      int          gap;
      logic [2:0]  d;
      int          span;
      repeat (5) @(negedge ref_clk);
      srst = 1'b0;
      cycles(10);
      wait_lvl(out_en, 1'b1, 20, "output on after reset");
      rd(CMD_OTW, RST_OTW);
      rd(CMD_UTW, RST_UTW);
      rd(CMD_UTF, RST_UTF);
      rd(CMD_UTR, {8'h00, RST_UTR});
      access(1'b0, 8'h99, 16'hFFFF, 17'h10000);
      wr(CMD_OTW, 16'hA5C3);
      rd(CMD_OTW, 16'hA5C3);
      wr(CMD_UTW, 16'h000F);
      rd(CMD_UTW, 16'h000F);
      wr(CMD_UTF, 16'h000A);
      rd(CMD_UTF, 16'h000A);
      wr(CMD_UTR, 16'h0000);
      rd(CMD_UTR, 16'h0000);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         wr(CMD_OTW, OT_T[i]);
         set_temp(TM_T[i]);
         cycles(4);
         check("warn flags", 17'(FL_T[i]), {14'h0, ot_warn, ut_warn, ut_fault});
      end
      cycles(40);
      check("ignored fault", 17'h1, {16'h0, out_en});
      $display("test limits done");
      for (int m = 0; m < 4; m++) begin
         set_temp(T_OK);
         cycles(4);
         wr(CMD_UTR, m[0] ? 16'h0080 : 16'h00C0);
         set_temp(T_COLD);
         wait_lvl(fault_latched, 1'b1, 10, "latched");
         check("output while latched", 17'h0, {16'h0, out_en});
         set_temp(T_OK);
         cycles(20);
         check("latch holds", 17'h1, {16'h0, fault_latched});
         case (m)
            0: wr(CMD_CLR, 16'h0000);
            1: wr(CMD_STAT, 16'h0010);
            2: begin
               wr(CMD_OPER, 16'h0000);
               wr(CMD_OPER, 16'h0080);
            end
            default: begin
               run_pin = 1'b0;
               cycles(6);
               run_pin = 1'b1;
            end
         endcase
         wait_lvl(out_en, 1'b1, 40, "on after clear");
      end
      $display("test latch done");
      for (int r = 1; r <= 6; r++) begin
         d        = 3'(r - 1);
         unit_len = 16'(1 + r % 3);
         span     = (1 << d) * (1 + r % 3);
         wr(CMD_UTR, {8'h00, 2'b10, 3'(r), d});
         set_temp(T_COLD);
         count_rises((r + 2) * span + 40, rises, gap);
         check("restart count", 17'(r), 17'(rises));
         if (r > 1) check("restart spacing", 17'(span), 17'(gap));
         check("off after retries", 17'h1, {16'h0, fault_latched});
         recover();
      end
      unit_len = 16'h0002;
      $display("test retries done");
      wr(CMD_UTR, 16'h00B9);
      set_temp(T_COLD);
      count_rises(200, rises, gap);
      check("endless restarts", 17'h1, {16'h0, rises > 6});
      check("never latched", 17'h0, {16'h0, fault_latched});
      ext_shutdown = 1'b1;
      wait_lvl(fault_latched, 1'b1, 10, "shutdown ends retries");
      ext_shutdown = 1'b0;
      wr(CMD_CLR, 16'h0000);
      run_pin = 1'b0;
      wait_lvl(out_en, 1'b0, 6, "stopped by pin");
      // pin needs two sync flops and the output register before it bites
      cycles(3);
      count_rises(20, rises, gap);
      check("restarts while off", 17'h0, 17'(rises));
      set_temp(T_OK);
      run_pin = 1'b1;
      wait_lvl(out_en, 1'b1, 40, "on again");
      $display("test endless done");
      wr(CMD_UTR, 16'h0042);
      set_temp(T_COLD);
      wait_lvl(ut_fault, 1'b1, 5, "fault flag");
      cycles(5);
      check("runs during delay", 17'h1, {16'h0, out_en});
      wait_lvl(fault_latched, 1'b1, 12, "off after delay");
      recover();
      set_temp(T_COLD);
      cycles(3);
      set_temp(T_OK);
      cycles(30);
      check("short fault ridden", 17'h2, {15'h0, out_en, fault_latched});
      ext_shutdown = 1'b1;
      wait_lvl(fault_latched, 1'b1, 10, "other fault stops");
      ext_shutdown = 1'b0;
      recover();
      $display("test delay done");
      // mid-run reset drops the latch; held long so the link side settles too
      wr(CMD_UTR, 16'h00C0);
      set_temp(T_COLD);
      wait_lvl(fault_latched, 1'b1, 10, "latched before reset");
      set_temp(T_OK);
      srst = 1'b1;
      cycles(10);
      srst = 1'b0;
      check("latch cleared by reset", 17'h0, {16'h0, fault_latched});
      cycles(10);
      check("on after reset", 17'h1, {16'h0, out_en});
      rd(CMD_OTW, RST_OTW);
      rd(CMD_OPER, {8'h00, RST_OPER});
      rd(CMD_STAT, 16'h0000);
      $display("test reset done");
      finish_test();
   end
endmodule : tlf_top_tb
